// ### design/adf_pkg.sv
// Constants shared by the converter readout block and its decimator
//
// Behaviour
// - FIFO period is 8 times level (4 times in double rate), level reads
// - Data-ready high at least one clock between
// - First data-ready 8 times (level+1) after reset, 4 times in double rate
// - Default decimation by 8 samples
// - Double-rate pin decimates by 4
// - Modulator takes one sample per clock
// - Three select pins set buffer depth, bit2 MSB
// - Positive overload gives largest positive code
// - Negative overload gives most negative code
// - Range flag high while input overloads
// - Data drives only while read and select low
// - Reset forces data-ready high, data low
// - Data-ready active low, falling edge marks data
// - Words are 16-bit two's complement, bit15 MSB
package adf_pkg;

  // ----------------------------------------------------------------
  // Word format and codes
  // ----------------------------------------------------------------
  localparam int          WORD_W     = 16;
  localparam logic [15:0] CODE_MAX   = 16'h7fff;
  localparam logic [15:0] CODE_MIN   = 16'h8000;
  localparam logic [15:0] DOUT_RST   = 16'h0000;

  // ----------------------------------------------------------------
  // Decimation and burst timing
  // ----------------------------------------------------------------
  localparam int          OSR_NORM   = 8;
  localparam int          OSR_DOUBLE = 4;
  localparam int          SEL_W      = 3;
  localparam int          DEPTH_MAX  = 8;
  localparam int          CNT_W      = 8;
  localparam int          DATA_AVAIL_N_HIGH_MIN = 1;
  localparam int          HOST_RD_WAIT  = 8;
  localparam int          HOST_RD_GAP   = 2;

  typedef enum logic {ADF_WARM, ADF_RUN} adf_state_t;

endpackage

// ### design/adf_word_if.sv
// Carrier for decimated words between the filter and the readout logic
`timescale 1ns/1ps
`default_nettype none
interface adf_word_if;
  logic        valid;
  logic [15:0] word;
  logic        over;
  modport src (output valid, output word, output over);
  modport dst (input valid, input word, input over);
endinterface
`default_nettype wire

// ### design/adf_decim.sv
// Boxcar decimator: averages modulator samples and clips to 16-bit codes
`timescale 1ns/1ps
`default_nettype none
module adf_decim
  import adf_pkg::*;
#(
  parameter int SAMPLE_W = 18
)(
  input  wire logic                clk_sys_i,     // System clock
  input  wire logic                rst_n_i,       // Async reset, low
  input  wire logic                ce_i,          // Clock enable
  input  wire logic [SAMPLE_W-1:0] mod_sample_i,  // Modulator sample
  input  wire logic                double_rate_i, // Decimate by four
  adf_word_if.src                  out            // Decimated words
);

  localparam int SUM_W = SAMPLE_W + 3;

  logic [2:0]             phase;
  logic [2:0]             next_phase;
  logic signed [SUM_W-1:0] acc;
  logic signed [SUM_W-1:0] next_acc;
  logic                   next_valid;
  logic [15:0]            next_word;
  logic                   next_over;
  logic signed [SUM_W-1:0] sum;
  logic signed [SUM_W-1:0] avg;
  logic [2:0]             last_phase;

  // ------------------------------------------------------------
  // Accumulate one sample per clock, dump every ratio samples
  // ------------------------------------------------------------
  always_comb
  begin
    last_phase = double_rate_i ? 3'(OSR_DOUBLE - 1) : 3'(OSR_NORM - 1);
    sum        = acc + SUM_W'($signed(mod_sample_i));
    avg        = double_rate_i ? (sum >>> 2) : (sum >>> 3);
    next_valid = 1'b0;
    next_word  = out.word;
    next_over  = out.over;
    next_acc   = sum;
    next_phase = phase + 3'd1;
    if (phase >= last_phase)
    begin
      next_phase = 3'd0;
      next_acc   = '0;
      next_valid = 1'b1;
      // Clip keeps the two's complement word honest on overload
      if (avg > SUM_W'($signed(CODE_MAX)))
      begin
        next_word = CODE_MAX;
        next_over = 1'b1;
      end
      else if (avg < SUM_W'($signed(CODE_MIN)))
      begin
        next_word = CODE_MIN;
        next_over = 1'b1;
      end
      else
      begin
        next_word = avg[15:0];
        next_over = 1'b0;
      end
    end
  end

  // Register filter state
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase     <= 3'd0;
      acc       <= '0;
      out.valid <= 1'b0;
      out.word  <= DOUT_RST;
      out.over  <= 1'b0;
    end
    else if (ce_i)
    begin
      phase     <= next_phase;
      acc       <= next_acc;
      out.valid <= next_valid;
      out.word  <= next_word;
      out.over  <= next_over;
    end
  end

endmodule
`default_nettype wire

// ### design/adf_readout.sv
// Converter digital output: decimation, burst buffer and parallel readout
`timescale 1ns/1ps
`default_nettype none
module adf_readout
  import adf_pkg::*;
#(
  parameter int SAMPLE_W = 18
)(
  input  wire logic                clk_sys_i,             // System clock
  input  wire logic                rst_n_i,               // Async reset, low
  input  wire logic                ce_i,                  // Clock enable
  input  wire logic [SAMPLE_W-1:0] mod_sample_i,          // Modulator sample
  input  wire logic                double_rate_select_i,  // Decimate by four
  input  wire logic [SEL_W-1:0]    burst_depth_sel_i,     // Buffer level, 0 off
  input  wire logic                rd_n_i,                // Read strobe, low
  input  wire logic                cs_n_i,                // Chip select, low
  output var  logic                data_avail_n_o,        // Data ready, low
  output var  logic                range_exceeded_flag_o, // Input overload
  output var  logic [WORD_W-1:0]   dout_o,                // Data word
  output var  logic                dout_oe_o              // Data bus enable
);

  // ----------------------------------------------------------------
  // Operating notes
  // ----------------------------------------------------------------
  // One modulator sample enters the filter on every enabled clock.
  // A burst is level words; data-ready falls one clock after the
  // last word of the burst leaves the filter.
  // With the buffer on, data-ready rises for one clock only, just
  // before the next burst, so the host has the rest of the period.
  // With the buffer off, data-ready is a square wave of one word.
  // Mode pins are not resynchronised: change them under reset, or
  // accept one disturbed period.
  // Reads past the last word of a burst keep showing that word.
  // The host must leave the strobe high two clocks before data-ready
  // moves; nothing here checks that.

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  adf_word_if dec ();

  adf_decim #(
    .SAMPLE_W (SAMPLE_W)
  ) u_decim (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .ce_i          (ce_i),
    .mod_sample_i  (mod_sample_i),
    .double_rate_i (double_rate_select_i),
    .out           (dec.src)
  );

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  adf_state_t        state;
  adf_state_t        next_state;
  logic [WORD_W-1:0] fill      [DEPTH_MAX];
  logic [WORD_W-1:0] next_fill [DEPTH_MAX];
  logic [WORD_W-1:0] bank      [DEPTH_MAX];
  logic [WORD_W-1:0] next_bank [DEPTH_MAX];
  logic [SEL_W-1:0]  wcnt;
  logic [SEL_W-1:0]  next_wcnt;
  logic [SEL_W-1:0]  ridx;
  logic [SEL_W-1:0]  next_ridx;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic              next_avail_n;
  logic              next_range;
  logic [WORD_W-1:0] next_dout;
  logic              strobe_prev;
  logic              strobe_now;
  logic              read_done;
  logic              fifo_en;
  logic [SEL_W-1:0]  level;
  logic [CNT_W-1:0]  osr;
  logic [CNT_W-1:0]  period;
  logic [CNT_W-1:0]  high_at;
  logic              burst;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Zero on the select pins means no buffering: one word per period
  always_comb
  begin
    fifo_en = (burst_depth_sel_i != '0);
    level   = fifo_en ? burst_depth_sel_i : SEL_W'(1);
    osr     = double_rate_select_i ? CNT_W'(OSR_DOUBLE) : CNT_W'(OSR_NORM);
    period  = CNT_W'(osr * CNT_W'(level));
    // Buffered: high only in the last clock; plain: square wave
    high_at = fifo_en ? CNT_W'(period - CNT_W'(DATA_AVAIL_N_HIGH_MIN + 1))
                      : CNT_W'((period >> 1) - CNT_W'(1));
  end

  // ----------------------------------------------------------------
  // Read strobe tracking
  // ----------------------------------------------------------------
  // A read counts when both strobes were low and one has risen
  // Strobe history resets to idle, so reset makes no false read
  always_comb
  begin
    strobe_now = ~rd_n_i & ~cs_n_i;
    read_done  = strobe_prev & ~strobe_now;
  end

  // ----------------------------------------------------------------
  // Burst collection and data-ready timing
  // ----------------------------------------------------------------
  // The first word after reset is thrown away while the filter
  // settles; this pushes the first data-ready to (level+1) words.
  always_comb
  begin
    next_state   = state;
    next_wcnt    = wcnt;
    next_fill    = fill;
    next_bank    = bank;
    next_range   = range_exceeded_flag_o;
    burst        = 1'b0;
    if (dec.valid)
    begin
      next_range = dec.over;
      if (state == ADF_WARM)
      begin
        next_state = ADF_RUN;
      end
      else
      begin
        next_fill[wcnt] = dec.word;
        if (wcnt >= level - SEL_W'(1))
        begin
          burst     = 1'b1;
          next_wcnt = '0;
          next_bank = next_fill;
        end
        else
        begin
          next_wcnt = wcnt + SEL_W'(1);
        end
      end
    end

    // Period counter restarts on each burst
    next_cnt     = cnt;
    next_avail_n = data_avail_n_o;
    if (burst)
    begin
      next_cnt     = '0;
      next_avail_n = 1'b0;
    end
    else
    begin
      if (cnt != '1)
      begin
        next_cnt = cnt + CNT_W'(1);
      end
      if (state == ADF_RUN && cnt >= high_at)
      begin
        next_avail_n = 1'b1;
      end
    end

    // Read pointer: oldest word first, holds on the last one
    next_ridx = ridx;
    if (burst)
    begin
      next_ridx = '0;
    end
    else if (read_done && ridx < level - SEL_W'(1))
    begin
      next_ridx = ridx + SEL_W'(1);
    end
    next_dout = next_bank[next_ridx];
  end

  // Register readout state; reset forces data-ready high, data low
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state                 <= ADF_WARM;
      wcnt                  <= '0;
      ridx                  <= '0;
      cnt                   <= '0;
      strobe_prev           <= 1'b0;
      data_avail_n_o        <= 1'b1;
      dout_o                <= DOUT_RST;
      range_exceeded_flag_o <= 1'b0;
      for (int i = 0; i < DEPTH_MAX; i++)
      begin
        fill[i] <= DOUT_RST;
        bank[i] <= DOUT_RST;
      end
    end
    else if (ce_i)
    begin
      state                 <= next_state;
      wcnt                  <= next_wcnt;
      ridx                  <= next_ridx;
      cnt                   <= next_cnt;
      strobe_prev           <= strobe_now;
      data_avail_n_o        <= next_avail_n;
      dout_o                <= next_dout;
      range_exceeded_flag_o <= next_range;
      fill                  <= next_fill;
      bank                  <= next_bank;
    end
  end

  // ----------------------------------------------------------------
  // Bus drive
  // ----------------------------------------------------------------
  // Drive only while both strobes are low; the pad floats otherwise
  // Enable is combinational so the bus lets go in the same clock as
  // the strobe; the word itself always comes from a flip-flop
  always_comb
  begin
    dout_oe_o = ~rd_n_i & ~cs_n_i;
  end

endmodule
`default_nettype wire

// ### sim/adf_readout_assertions.sv
// Checker for the readout block ports
`timescale 1ns/1ps
`default_nettype none
module adf_chk
  import adf_pkg::*;
(
  input wire logic              clk_sys_i,            // Clock
  input wire logic              rst_n_i,              // Reset
  input wire logic              double_rate_select_i, // Rate
  input wire logic [SEL_W-1:0]  burst_depth_sel_i,    // Depth
  input wire logic              rd_n_i,               // Read
  input wire logic              cs_n_i,               // Select
  input wire logic              data_avail_n_o,       // Ready
  input wire logic [WORD_W-1:0] dout_o,               // Word
  input wire logic              dout_oe_o             // Drive
);
  // ------
  // Counters
  // ------
  logic [7:0] age, next_age, gap, next_gap;
  logic       seen, next_seen, prv, fall;
  logic [3:0] osr, lvl;
  // Expected ratio and depth from the pins
  assign osr  = double_rate_select_i ? 4'h4 : 4'h8;
  assign lvl  = (burst_depth_sel_i == 3'h0) ? 4'h1 : {1'b0, burst_depth_sel_i};
  assign fall = prv & ~data_avail_n_o;
  // Saturating, so a stuck output cannot wrap back into range
  always_comb
  begin
    next_age  = (age == 8'hff) ? age : age + 8'h01;
    next_gap  = fall ? 8'h01 : ((gap == 8'hff) ? gap : gap + 8'h01);
    next_seen = seen | fall;
  end
  // Counter registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
      {age, gap, seen, prv} <= 18'h00001;
    else
      {age, gap, seen, prv} <= {next_age, next_gap, next_seen, data_avail_n_o};
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_BUS_DRIVE: assert property (dout_oe_o == (!rd_n_i && !cs_n_i))
    else $error("bus drive mismatch");
  AST_RESET_STATE: assert property (disable iff (1'b0)
    !rst_n_i |-> data_avail_n_o && dout_o == DOUT_RST) else $error("reset state");
  AST_HIGH_GAP: assert property ($rose(data_avail_n_o) && burst_depth_sel_i != 3'h0
    |=> $fell(data_avail_n_o)) else $error("ready high gap");
  AST_LOW_HOLD: assert property ($fell(data_avail_n_o) |=> !data_avail_n_o)
    else $error("ready low too short");
  AST_RATE_NORM: assert property (fall && seen && !double_rate_select_i
    && burst_depth_sel_i != 3'h0 |-> gap == osr * lvl) else $error("normal period");
  AST_RATE_DBL: assert property (fall && seen && double_rate_select_i
    && burst_depth_sel_i != 3'h0 |-> gap == osr * lvl) else $error("double period");
  AST_FIRST_READY: assert property (fall && !seen |-> age >= osr * (lvl + 4'h1)
    && age <= osr * (lvl + 4'h1) + 8'h04) else $error("first ready");
  AST_READ_HOLD: assert property (dout_oe_o && $past(dout_oe_o)
    && !$fell(data_avail_n_o) |-> $stable(dout_o)) else $error("word moved in read");
endmodule
bind adf_readout adf_chk chk_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .double_rate_select_i(double_rate_select_i), .burst_depth_sel_i(burst_depth_sel_i),
  .rd_n_i(rd_n_i), .cs_n_i(cs_n_i), .data_avail_n_o(data_avail_n_o), .dout_o(dout_o),
  .dout_oe_o(dout_oe_o));
`default_nettype wire

// ### sim/adf_host.sv
// Host reader model: pulls a burst of words after each ready fall
`timescale 1ns/1ps
`default_nettype none
module adf_host
(
  input  wire logic        clk_sys_i, // Clock
  input  wire logic        rst_n_i,   // Reset
  input  wire logic        ready_n_i, // Data ready
  input  wire logic [15:0] bus_i,     // Resolved bus
  input  wire logic [2:0]  reads_i,   // Words per burst
  output var  logic        rd_n_o,    // Read strobe
  output var  logic        cs_n_o,    // Chip select
  output var  logic [15:0] word_o,    // Captured word
  output var  logic        got_o      // Word taken
);
  logic [7:0] age;
  logic [2:0] left;
  logic [1:0] ph;
  logic       prv;
  // Strobe low two cycles; bus taken on the edge that ends it
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      {rd_n_o, cs_n_o, got_o, left, ph, prv, age} <= {3'b110, 5'h00, 1'b1, 8'h00};
    else
    begin
      prv   <= ready_n_i;
      got_o <= 1'b0;
      age   <= (age == 8'hff) ? age : age + 8'h01;
      if (prv && !ready_n_i && age >= 8'h08 && reads_i != 3'h0)
      begin
        left   <= reads_i;
        ph     <= 2'h0;
        cs_n_o <= 1'b0;
      end
      else if (left != 3'h0)
      begin
        ph     <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        rd_n_o <= (ph == 2'h2);
        if (ph == 2'h2)
        begin
          word_o <= bus_i;
          got_o  <= 1'b1;
          left   <= left - 3'h1;
          cs_n_o <= (left == 3'h1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/adc_fifo_parallel_readout_bench.sv
// Testbench for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module adc_fifo_parallel_readout_bench
  import adf_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b1, dr = 1'b0, rd_n, cs_n, ready_n, flag, oe, got;
  logic        ce = 1'b1;
  logic [2:0]  sel = 3'h1, reads = 3'h0;
  logic [17:0] smp = 18'h00000;
  logic [15:0] dout, word;
  wire  [15:0] bus = oe ? dout : ~dout; // Released bus never shows the word
  int          fails = 0, checked = 0, cyc = 0;
  // Clock and parts
  always #25 clk = ~clk;
  adf_readout dut_u (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce), .mod_sample_i(smp),
    .double_rate_select_i(dr), .burst_depth_sel_i(sel), .rd_n_i(rd_n), .cs_n_i(cs_n),
    .data_avail_n_o(ready_n), .range_exceeded_flag_o(flag), .dout_o(dout), .dout_oe_o(oe));
  adf_host host_u (.clk_sys_i(clk), .rst_n_i(rst_n), .ready_n_i(ready_n), .bus_i(bus),
    .reads_i(reads), .rd_n_o(rd_n), .cs_n_o(cs_n), .word_o(word), .got_o(got));
  // Hang guard; the whole run needs well under 1500 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails = fails + 1;
      end_of_test;
    end
  end
  // ------
  // Checks and runs
  // ------
  task automatic cmp_w(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Mode set under reset: pins are not resynchronised mid-period
  task automatic run(input logic [2:0] s, input logic d, input logic [17:0] m,
                     input logic [15:0] ew, input logic ef, input logic [2:0] r);
    int   n;
    int   falls;
    logic pv;
    // Start on an edge so reset and mode pins move with the clock
    @(posedge clk);
    rst_n <= 1'b0;
    sel   <= s;
    dr    <= d;
    smp   <= m;
    reads <= r;
    @(posedge clk);
    #1;
    cmp_w("reset word", DOUT_RST, dout);
    cmp_w("reset ready", 16'h0001, {15'h0000, ready_n});
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    n     = 0;
    falls = 0;
    pv    = 1'b1;
    while (falls < 3)
    begin
      @(posedge clk);
      #1;
      if (pv && !ready_n)
      begin
        falls++;
        cmp_w("burst word", ew, dout);
        cmp_w("range flag", {15'h0000, ef}, {15'h0000, flag});
      end
      if (got)
      begin
        n++;
        cmp_w("read word", ew, word);
      end
      pv = ready_n;
    end
    cmp_w("words read", {12'h000, r, 1'b0}, 16'(n));
  endtask
  task automatic t_default_rate;
    run(3'h2, 1'b0, 18'h00123, 16'h0123, 1'b0, 3'h2);
  endtask
  task automatic t_double_rate;
    run(3'h4, 1'b1, 18'h3fedc, 16'hfedc, 1'b0, 3'h4);
  endtask
  task automatic t_positive_clip;
    run(3'h7, 1'b0, 18'h1ffff, CODE_MAX, 1'b1, 3'h7);
  endtask
  task automatic t_negative_clip;
    run(3'h1, 1'b0, 18'h20000, CODE_MIN, 1'b1, 3'h1);
  endtask
  task automatic t_buffer_off;
    run(3'h0, 1'b0, 18'h00040, 16'h0040, 1'b0, 3'h0);
  endtask
  // Enable low must freeze the square wave of the unbuffered mode
  task automatic t_clock_hold;
    int   moves;
    logic pv;
    @(posedge clk);
    ce    <= 1'b0;
    moves = 0;
    @(posedge clk);
    #1;
    pv = ready_n;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      if (ready_n !== pv)
        moves++;
      pv = ready_n;
    end
    cmp_w("ready moves while held", 16'h0000, 16'(moves));
  endtask
  task automatic end_of_test;
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_default_rate;
    t_double_rate;
    t_positive_clip;
    t_negative_clip;
    t_buffer_off;
    t_clock_hold;
    end_of_test;
  end
endmodule
`default_nettype wire
